// ---- ctl_decoder_defines.vh ----
`ifndef CTL_DECODER_DEFINES_VH
`define CTL_DECODER_DEFINES_VH

// Decoder states
`define ST_RUN       3'h0
`define ST_WORD2     3'h1
`define ST_DISCARD   3'h2
`define ST_STALL     3'h3
`define ST_SKIP      3'h4
`define ST_SKIP2     3'h5

// Upper nibble opcodes
`define OP_SKIP_CLR  4'hb
`define OP_SKIP_SET  4'ha
`define OP_BIT_CLR   4'h9
`define OP_BIT_SET   4'h8
`define OP_BIT_TGL   4'h7
`define OP_REL       4'hd
`define OP_SECOND    4'hf
`define OP_MOVE_FF   4'hc
`define OP_ZERO      4'h0

// Longer prefixes
`define PFX_COND     5'h1c
`define PFX_CALL     7'h76
`define PFX_JUMP     8'hef
`define PFX_LPTR     10'h3b8
`define PFX_BANK     12'h010

// Control words with upper byte zero: the low byte, or its bits 7:1 (RETI, RET) or 7:2 (TBL)
`define CW_KICK      8'h04
`define CW_STANDBY   8'h03
`define CW_RESET     8'hff
`define CW_PUSH      8'h05
`define CW_POP       8'h06
`define CW_RETI      7'h08
`define CW_RET       7'h09
`define CW_TBL_RD    6'h02
`define CW_TBL_WR    6'h03

// Literal group, bits 11:8
`define LIT_ADD      4'hf
`define LIT_SUB      4'h8
`define LIT_AND      4'hb
`define LIT_OR       4'h9
`define LIT_XOR      4'ha
`define LIT_MOV      4'he
`define LIT_MUL      4'hd
`define LIT_RETW     4'hc

// Working register operations
`define ALU_NONE     3'h0
`define ALU_ADD      3'h1
`define ALU_SUB      3'h2
`define ALU_AND      3'h3
`define ALU_OR       3'h4
`define ALU_XOR      3'h5
`define ALU_MOV      3'h6
`define ALU_MUL      3'h7

// Bit operations
`define BOP_CLR      2'h0
`define BOP_SET      2'h1
`define BOP_TGL      2'h2

// Status update mask
`define FLG_ARITH    5'h1f
`define FLG_LOGIC    5'h14
`define FLG_NONE     5'h00

// Pending two-word kinds
`define PK_CALL      2'h0
`define PK_JUMP      2'h1
`define PK_LPTR      2'h2

`endif

// ---- rel_target_calc.v ----
`timescale 1ns/100ps
`default_nettype none

// Adds a signed word offset to the following-instruction address
module rel_target_calc #(
    parameter ADDR_W = 20,
    parameter OFF_W  = 11
) (
    input  wire [ADDR_W-1:0] base_in,
    input  wire [OFF_W-1:0]  offset_in,
    output wire [ADDR_W-1:0] target_out
);

    wire [ADDR_W-1:0] offset_ext;

    // Sign extension, then wrap within the address space
    assign offset_ext = {{(ADDR_W-OFF_W){offset_in[OFF_W-1]}}, offset_in};
    assign target_out = base_in + offset_ext;

endmodule // rel_target_calc

`default_nettype wire

// ---- control_literal_table_decoder.v ----
// Function
// [RL1] 1011 tests bit, skips next word if zero
// [RL2] 1010 tests bit, skips next word if one
// [RL3] 11100 plus condition code branches, two cycles if taken
// [RL4] 1101 is relative branch, or relative call when bit 11 set
// [RL5] 1110110s opens two-word call with fast bit
// [RL6] 11101111 opens two-word absolute jump
// [RL7] 0004 kicks watchdog, updates timeout and power flags
// [RL8] 0003 enters standby, updates timeout and power flags
// [RL9] 00ff is software reset, all status bits affected
// [RL10] Control words 0005 push and 0006 pop the return stack
// [RL11] 000s returns from interrupt, restoring enables; 001s plain return
// [RL12] 0Cxx returns and loads literal into working register, two cycles
// [RL13] 0Fxx adds literal, 08xx subtracts working reg; arithmetic flags
// [RL14] 0Bxx and, 09xx or, 0Axx xor literal; only zero and negative
// [RL15] 0Exx loads literal, 0Dxx multiplies; no flag changes
// [RL16] 010k loads four bits into bank select register low nibble
// [RL17] EE0f plus F0kk loads 12-bit literal into chosen pointer register
// [RL18] 0008-000B table read with four pointer modes, two cycles
// [RL19] 000C-000F table write with four pointer modes, two cycles
// [RL20] Program counter change or true test costs a second no-op cycle
// [RL21] Nibble 1111 runs as no-op unless consumed as a second word
// [RL22] Port read-modify-write uses pin levels instead of output latch
// [RL23] Access bit zero selects access bank, one uses bank select register
// [RL24] Three-bit field gives bit position zero to seven
// [RL25] Two-word call and jump join 8 low and 12 high target bits
// [RL26] Relative offsets are signed word counts from following address
`timescale 1ns/100ps
`default_nettype none
`include "ctl_decoder_defines.vh"

module control_literal_table_decoder #(
    parameter ADDR_W = 20
) (
    input  wire              ref_clk_in,
    input  wire              reset_n_in,
    input  wire              clk_en_in,
    input  wire              instr_valid_in,
    input  wire [15:0]       instr_word_in,
    input  wire [ADDR_W-1:0] next_pc_in,
    input  wire              zero_flag_in,
    input  wire              carry_flag_in,
    input  wire              overflow_flag_in,
    input  wire              negative_flag_in,
    input  wire              test_bit_in,
    input  wire              port_addr_hit_in,
    output reg               exec_valid_out,
    output reg               nop_cycle_out,
    output reg               stall_out,
    output reg               skip_taken_out,
    output reg  [7:0]        literal_out,
    output reg  [7:0]        file_addr_out,
    output reg  [2:0]        bit_pos_out,
    output reg               use_bank_out,
    output reg               bit_write_out,
    output reg  [1:0]        bit_op_out,
    output reg               use_pin_levels_out,
    output reg               load_pc_out,
    output reg  [ADDR_W-1:0] target_out,
    output reg               push_return_out,
    output reg               fast_out,
    output reg               return_out,
    output reg               irq_restore_out,
    output reg               stack_push_out,
    output reg               stack_pop_out,
    output reg               working_reg_write_out,
    output reg  [2:0]        alu_op_out,
    output reg  [4:0]        flag_update_out,
    output reg               watchdog_kick_out,
    output reg               standby_out,
    output reg               soft_reset_out,
    output reg               bank_load_out,
    output reg               ptr_load_out,
    output reg  [1:0]        ptr_sel_out,
    output reg  [11:0]       ptr_value_out,
    output reg               table_read_out,
    output reg               table_write_out,
    output reg  [1:0]        table_mode_out
);

    ////////////////////////////////////////////////////////////////////
    // State and pending first-word fields
    reg [2:0] state, next_state;
    reg [1:0] pend_kind, next_pend_kind;
    reg [7:0] pend_low, next_pend_low;
    reg       pend_fast, next_pend_fast;
    reg [1:0] pend_sel, next_pend_sel;
    reg [3:0] pend_hi, next_pend_hi;

    reg              next_exec, next_nop, next_stall, next_skip;
    reg [7:0]        next_lit, next_faddr;
    reg [2:0]        next_bpos;
    reg              next_bank_sel, next_bwr;
    reg [1:0]        next_bop;
    reg              next_pins, next_load_pc;
    reg [ADDR_W-1:0] next_target;
    reg              next_push_ret, next_fast, next_ret, next_irq;
    reg              next_spush, next_spop, next_working_reg;
    reg [2:0]        next_alu;
    reg [4:0]        next_flg;
    reg              next_kick, next_standby, next_reset;
    reg              next_bank_ld, next_ptr_ld;
    reg [1:0]        next_ptr_sel;
    reg [11:0]       next_ptr_val;
    reg              next_trd, next_twr;
    reg [1:0]        next_tmode;

    wire [15:0] w = instr_word_in;
    wire [3:0]  hi4 = instr_word_in[15:12];

    ////////////////////////////////////////////////////////////////////
    // Relative targets
    wire [10:0]       off8_ext = {{3{w[7]}}, w[7:0]};
    wire [ADDR_W-1:0] tgt_short, tgt_long;

    // [RL26] signed short offset
    rel_target_calc #(.ADDR_W(ADDR_W), .OFF_W(11)) u_short (
        .base_in    (next_pc_in),
        .offset_in  (off8_ext),
        .target_out (tgt_short)
    );

    // [RL26] signed long offset
    rel_target_calc #(.ADDR_W(ADDR_W), .OFF_W(11)) u_long (
        .base_in    (next_pc_in),
        .offset_in  (w[10:0]),
        .target_out (tgt_long)
    );

    // Two-word openers
    wire two_word = (hi4 == `OP_MOVE_FF) || (w[15:9] == `PFX_CALL) ||
                    (w[15:8] == `PFX_JUMP) || (w[15:6] == `PFX_LPTR);

    // [RL3] bits 10:9 pick the flag, bit 8 inverts it
    wire cond_true = w[8] ^ (w[10] ? (w[9] ? negative_flag_in : overflow_flag_in) :
                                     (w[9] ? carry_flag_in : zero_flag_in));

    ////////////////////////////////////////////////////////////////////
    // Decode and sequencing
    always @* begin
        next_state     = state;
        next_pend_kind = pend_kind;
        next_pend_low  = pend_low;
        next_pend_fast = pend_fast;
        next_pend_sel  = pend_sel;
        next_pend_hi   = pend_hi;
        next_exec = 1'b0; next_nop = 1'b0; next_stall = 1'b0;
        next_skip = 1'b0; next_lit = w[7:0]; next_faddr = w[7:0];
        next_bpos = w[11:9]; next_bank_sel = w[8];
        next_bwr = 1'b0; next_bop = `BOP_CLR; next_pins = 1'b0;
        next_load_pc = 1'b0; next_target = {ADDR_W{1'b0}};
        next_push_ret = 1'b0; next_fast = 1'b0; next_ret = 1'b0;
        next_irq = 1'b0; next_spush = 1'b0; next_spop = 1'b0;
        next_working_reg = 1'b0; next_alu = `ALU_NONE; next_flg = `FLG_NONE;
        next_kick = 1'b0; next_standby = 1'b0; next_reset = 1'b0;
        next_bank_ld = 1'b0; next_ptr_ld = 1'b0; next_ptr_sel = pend_sel;
        next_ptr_val = 12'h000; next_trd = 1'b0; next_twr = 1'b0;
        next_tmode = w[1:0];
        case (state)
            `ST_RUN: if (instr_valid_in) begin
                next_exec = 1'b1;
                // [RL1] [RL2] bit test and skip
                if (hi4 == `OP_SKIP_CLR || hi4 == `OP_SKIP_SET) begin
                    next_skip = (hi4 == `OP_SKIP_CLR) ? ~test_bit_in : test_bit_in;
                    if (next_skip)
                        next_state = `ST_SKIP;
                // [RL22] bit writes on a port read the pins
                end else if (hi4 == `OP_BIT_CLR || hi4 == `OP_BIT_SET ||
                             hi4 == `OP_BIT_TGL) begin
                    next_bwr  = 1'b1;
                    next_bop  = (hi4 == `OP_BIT_CLR) ? `BOP_CLR :
                                (hi4 == `OP_BIT_SET) ? `BOP_SET : `BOP_TGL;
                    next_pins = port_addr_hit_in;
                // [RL3] conditional branch, extra cycle when taken
                end else if (w[15:11] == `PFX_COND) begin
                    if (cond_true) begin
                        next_load_pc = 1'b1;
                        next_target  = tgt_short;
                        next_state   = `ST_DISCARD;
                    end
                // [RL4] relative branch and call
                end else if (hi4 == `OP_REL) begin
                    next_load_pc  = 1'b1;
                    next_target   = tgt_long;
                    next_push_ret = w[11];
                    next_state    = `ST_DISCARD;
                // [RL5] [RL6] [RL17] two-word openers
                end else if (two_word && hi4 != `OP_MOVE_FF) begin
                    next_pend_kind = (w[15:9] == `PFX_CALL) ? `PK_CALL :
                                     (w[15:8] == `PFX_JUMP) ? `PK_JUMP : `PK_LPTR;
                    next_pend_low  = w[7:0];
                    next_pend_fast = w[8];
                    next_pend_sel  = w[5:4];
                    next_pend_hi   = w[3:0];
                    next_state     = `ST_WORD2;
                // [RL21] stray second word is a no-op
                end else if (hi4 == `OP_SECOND) begin
                    next_nop = 1'b1;
                // [RL16] bank select load
                end else if (w[15:4] == `PFX_BANK) begin
                    next_bank_ld = 1'b1;
                    next_lit     = {4'h0, w[3:0]};
                end else if (w[15:8] == 8'h00) begin
                    // [RL18] [RL19] [RL11] control words
                    if (w[7:2] == `CW_TBL_RD) begin
                        next_trd   = 1'b1;
                        next_state = `ST_STALL;
                    end else if (w[7:2] == `CW_TBL_WR) begin
                        next_twr   = 1'b1;
                        next_state = `ST_STALL;
                    end else if (w[7:1] == `CW_RETI || w[7:1] == `CW_RET) begin
                        next_ret   = 1'b1;
                        next_irq   = (w[7:1] == `CW_RETI);
                        next_fast  = w[0];
                        next_state = `ST_DISCARD;
                    end else begin
                        case (w[7:0])
                            // [RL7] watchdog kick
                            `CW_KICK:    next_kick    = 1'b1;
                            // [RL8] standby entry
                            `CW_STANDBY: next_standby = 1'b1;
                            // [RL9] software reset
                            `CW_RESET:   next_reset   = 1'b1;
                            // [RL10] return stack push and pop
                            `CW_PUSH:    next_spush   = 1'b1;
                            `CW_POP:     next_spop    = 1'b1;
                            default:     next_nop     = 1'b1;
                        endcase
                    end
                end else if (hi4 == `OP_ZERO && w[11]) begin
                    // [RL13] [RL14] [RL15] [RL12] literal group
                    next_working_reg = 1'b1;
                    case (w[11:8])
                        `LIT_ADD: begin next_alu = `ALU_ADD; next_flg = `FLG_ARITH; end
                        `LIT_SUB: begin next_alu = `ALU_SUB; next_flg = `FLG_ARITH; end
                        `LIT_AND: begin next_alu = `ALU_AND; next_flg = `FLG_LOGIC; end
                        `LIT_OR:  begin next_alu = `ALU_OR;  next_flg = `FLG_LOGIC; end
                        `LIT_XOR: begin next_alu = `ALU_XOR; next_flg = `FLG_LOGIC; end
                        `LIT_MOV: next_alu = `ALU_MOV;
                        `LIT_MUL: begin next_alu = `ALU_MUL; next_working_reg = 1'b0; end
                        `LIT_RETW: begin
                            next_alu   = `ALU_MOV;
                            next_ret   = 1'b1;
                            next_state = `ST_DISCARD;
                        end
                        default: next_working_reg = 1'b0;
                    endcase
                end
            end
            // [RL25] [RL17] second word completes the opener
            `ST_WORD2: if (instr_valid_in) begin
                next_exec  = 1'b1;
                next_state = `ST_RUN;
                if (pend_kind == `PK_LPTR) begin
                    next_ptr_ld  = 1'b1;
                    next_ptr_val = {pend_hi, w[7:0]};
                end else begin
                    next_load_pc  = 1'b1;
                    next_target   = {w[11:0], pend_low};
                    next_push_ret = (pend_kind == `PK_CALL);
                    next_fast     = (pend_kind == `PK_CALL) & pend_fast;
                end
            end
            // [RL20] stale prefetch dropped
            `ST_DISCARD: if (instr_valid_in) begin
                next_nop   = 1'b1;
                next_state = `ST_RUN;
            end
            // Table access second cycle
            `ST_STALL: begin
                next_nop   = 1'b1;
                next_state = `ST_RUN;
            end
            // [RL20] skipped words run as no-op
            `ST_SKIP: if (instr_valid_in) begin
                next_nop   = 1'b1;
                next_state = two_word ? `ST_SKIP2 : `ST_RUN;
            end
            `ST_SKIP2: if (instr_valid_in) begin
                next_nop   = 1'b1;
                next_state = `ST_RUN;
            end
            default: next_state = `ST_RUN;
        endcase
        // Fetch repeats its word in the stall cycle
        next_stall = (next_state == `ST_STALL);
    end

    ////////////////////////////////////////////////////////////////////
    // Registered state and outputs
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= `ST_RUN; pend_kind <= `PK_CALL; pend_low <= 8'h00;
            pend_fast <= 1'b0; pend_sel <= 2'h0; pend_hi <= 4'h0;
            exec_valid_out <= 1'b0; nop_cycle_out <= 1'b0;
            stall_out <= 1'b0; skip_taken_out <= 1'b0;
            literal_out <= 8'h00; file_addr_out <= 8'h00;
            bit_pos_out <= 3'h0; use_bank_out <= 1'b0;
            bit_write_out <= 1'b0; bit_op_out <= `BOP_CLR;
            use_pin_levels_out <= 1'b0; load_pc_out <= 1'b0;
            target_out <= {ADDR_W{1'b0}}; push_return_out <= 1'b0;
            fast_out <= 1'b0; return_out <= 1'b0; irq_restore_out <= 1'b0;
            stack_push_out <= 1'b0; stack_pop_out <= 1'b0;
            working_reg_write_out <= 1'b0; alu_op_out <= `ALU_NONE;
            flag_update_out <= `FLG_NONE; watchdog_kick_out <= 1'b0;
            standby_out <= 1'b0; soft_reset_out <= 1'b0;
            bank_load_out <= 1'b0; ptr_load_out <= 1'b0;
            ptr_sel_out <= 2'h0; ptr_value_out <= 12'h000;
            table_read_out <= 1'b0; table_write_out <= 1'b0;
            table_mode_out <= 2'h0;
        end else if (clk_en_in) begin
            state <= next_state; pend_kind <= next_pend_kind;
            pend_low <= next_pend_low; pend_fast <= next_pend_fast;
            pend_sel <= next_pend_sel; pend_hi <= next_pend_hi;
            exec_valid_out <= next_exec; nop_cycle_out <= next_nop;
            stall_out <= next_stall; skip_taken_out <= next_skip;
            literal_out <= next_lit; file_addr_out <= next_faddr;
            // [RL24] [RL23] bit position and bank choice
            bit_pos_out <= next_bpos; use_bank_out <= next_bank_sel;
            bit_write_out <= next_bwr; bit_op_out <= next_bop;
            use_pin_levels_out <= next_pins; load_pc_out <= next_load_pc;
            target_out <= next_target; push_return_out <= next_push_ret;
            fast_out <= next_fast; return_out <= next_ret;
            irq_restore_out <= next_irq; stack_push_out <= next_spush;
            stack_pop_out <= next_spop; working_reg_write_out <= next_working_reg;
            alu_op_out <= next_alu; flag_update_out <= next_flg;
            watchdog_kick_out <= next_kick; standby_out <= next_standby;
            soft_reset_out <= next_reset; bank_load_out <= next_bank_ld;
            ptr_load_out <= next_ptr_ld; ptr_sel_out <= next_ptr_sel;
            ptr_value_out <= next_ptr_val; table_read_out <= next_trd;
            table_write_out <= next_twr; table_mode_out <= next_tmode;
        end
    end

endmodule // control_literal_table_decoder

`default_nettype wire

// ---- decoder_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ctl_decoder_defines.vh"
module decoder_sva #(parameter ADDR_W = 20) (
    input wire logic              ref_clk_in,
    input wire logic              reset_n_in,
    input wire logic              clk_en_in,
    input wire logic [15:0]       instr_word_in,
    input wire logic [ADDR_W-1:0] next_pc_in,
    input wire logic              nop_cycle_out,
    input wire logic              stall_out,
    input wire logic              skip_taken_out,
    input wire logic [7:0]        literal_out,
    input wire logic              load_pc_out,
    input wire logic [ADDR_W-1:0] target_out,
    input wire logic              return_out,
    input wire logic [2:0]        alu_op_out,
    input wire logic [4:0]        flag_update_out,
    input wire logic              bank_load_out,
    input wire logic              table_read_out,
    input wire logic              table_write_out
);
    // Expected relative target and bank literal
    wire [ADDR_W-1:0] rel_sum = next_pc_in
                              + {{(ADDR_W-11){instr_word_in[10]}}, instr_word_in[10:0]};
    wire [7:0]        low_nib = {4'h0, instr_word_in[3:0]};
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence table_op_s; (table_read_out || table_write_out) && clk_en_in; endsequence
    sequence one_stall_s; stall_out ##1 (!stall_out && nop_cycle_out); endsequence
    table_stall_a: assert property (table_op_s |-> one_stall_s)
        else $error("table stall wrong");
    return_drop_a: assert property (return_out && clk_en_in |=> nop_cycle_out)
        else $error("return kept prefetch");
    skip_drop_a: assert property (skip_taken_out && clk_en_in |=> nop_cycle_out)
        else $error("skip kept next word");
    add_decode_a: assert property (alu_op_out == `ALU_ADD && $past(clk_en_in) |->
        ($past(instr_word_in) & 16'hff00) == 16'h0f00 && flag_update_out == `FLG_ARITH)
        else $error("add decode or flags wrong");
    logic_flags_a: assert property (
        alu_op_out inside {`ALU_AND, `ALU_OR, `ALU_XOR} |-> flag_update_out == `FLG_LOGIC)
        else $error("logic flags wrong");
    plain_flags_a: assert property (
        alu_op_out inside {`ALU_MOV, `ALU_MUL} |-> flag_update_out == `FLG_NONE)
        else $error("move flags wrong");
    rel_target_a: assert property (load_pc_out && $past(clk_en_in) &&
        ($past(instr_word_in) & 16'hf000) == 16'hd000 |-> target_out == $past(rel_sum))
        else $error("relative target wrong");
    bank_lit_a: assert property (
        bank_load_out && $past(clk_en_in) |-> literal_out == $past(low_nib))
        else $error("bank literal wrong");
endmodule // decoder_sva
bind control_literal_table_decoder decoder_sva #(.ADDR_W(ADDR_W)) u_sva (.*);
`default_nettype wire

// ---- fetch_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module fetch_model (
    input  wire logic        clk_in,
    input  wire logic        start_in,
    input  wire logic        stall_in,
    output var  logic        valid_out,
    output wire logic [15:0] word_out,
    output wire logic [19:0] next_pc_out
);
    logic [15:0] mem [0:7];
    logic [2:0]  pc;
    // Empty words are bit-set ops: no pulse, no no-op
    initial begin
        valid_out = 1'b0;
        pc = 3'h7;
        for (int i = 0; i < 8; i++) mem[i] = 16'h8000;
    end
    // Advance unless stalled
    always @(posedge clk_in) begin
        if (start_in) pc <= 3'h0;
        else if (valid_out && !stall_in && pc != 3'h7) pc <= pc + 3'h1;
        valid_out <= valid_out | start_in;
    end
    assign word_out = mem[pc];
    assign next_pc_out = 20'h00101 + {17'h0, pc};
endmodule // fetch_model
`default_nettype wire

// ---- tb_control_literal_table_decoder.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_control_literal_table_decoder;
    logic        ref_clk_in, reset_n_in, start, test_bit, vld, stall, nop;
    logic [3:0]  flg;
    logic [15:0] word, seen;
    logic [19:0] npc, target, cap_target;
    logic [7:0]  lit, cap_lit;
    logic [2:0]  alu, cap_alu;
    logic [4:0]  flgu, cap_flg;
    logic [1:0]  psel, tmode, cap_mode;
    logic [11:0] pval;
    logic [13:0] cap_ptr;
    wire  [15:0] pv;
    int          errors, total_checks, nops;
    fetch_model PM (.clk_in(ref_clk_in), .start_in(start), .stall_in(stall), .valid_out(vld),
        .word_out(word), .next_pc_out(npc));
    control_literal_table_decoder DUT (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .clk_en_in(1'b1), .instr_valid_in(vld), .instr_word_in(word), .next_pc_in(npc),
        .zero_flag_in(flg[0]), .carry_flag_in(flg[1]), .overflow_flag_in(flg[2]),
        .negative_flag_in(flg[3]), .test_bit_in(test_bit), .port_addr_hit_in(1'b0),
        .exec_valid_out(), .nop_cycle_out(nop), .stall_out(stall), .skip_taken_out(pv[0]),
        .literal_out(lit), .file_addr_out(), .bit_pos_out(), .use_bank_out(),
        .bit_write_out(), .bit_op_out(), .use_pin_levels_out(), .load_pc_out(pv[15]),
        .target_out(target), .push_return_out(pv[14]), .fast_out(pv[13]),
        .return_out(pv[12]), .irq_restore_out(pv[11]), .stack_push_out(pv[10]),
        .stack_pop_out(pv[9]), .working_reg_write_out(pv[8]), .alu_op_out(alu),
        .flag_update_out(flgu), .watchdog_kick_out(pv[7]), .standby_out(pv[6]),
        .soft_reset_out(pv[5]), .bank_load_out(pv[4]), .ptr_load_out(pv[3]),
        .ptr_sel_out(psel), .ptr_value_out(pval), .table_read_out(pv[2]),
        .table_write_out(pv[1]), .table_mode_out(tmode));
    // Clock
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    // Gather pulses once outputs settle
    always @(posedge ref_clk_in) begin
        #1;
        seen = seen | pv;
        if (nop === 1'b1) nops++;
        if (pv[15] === 1'b1) cap_target = target;
        if (alu !== 3'h0) {cap_alu, cap_flg} = {alu, flgu};
        if (pv[8] | pv[4] | (alu !== 3'h0)) cap_lit = lit;
        if (pv[3] === 1'b1) cap_ptr = {psel, pval};
        if (pv[2] | pv[1]) cap_mode = tmode;
    end
    task chk(input string nm, input logic [19:0] e, g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task ends(input logic [15:0] es, input int en);
        chk("pulses", {4'h0, es}, {4'h0, seen});
        chk("nops", 20'(en), 20'(nops));
    endtask
    task run(input logic [15:0] w0, w1);
        @(negedge ref_clk_in);
        {PM.mem[0], PM.mem[1], seen, nops, start} = {w0, w1, 16'h0, 32'h0, 1'b1};
        {cap_target, cap_lit, cap_alu, cap_flg, cap_ptr, cap_mode} = '0;
        @(negedge ref_clk_in);
        start = 1'b0;
        repeat (8) @(negedge ref_clk_in);
    endtask
    task two_word_ops;
        run(16'hef34, 16'hf567);
        ends(16'h8000, 0);
        chk("target", 20'h56734, cap_target);
        run(16'hed12, 16'hfabc);
        ends(16'he000, 0);
        chk("target", 20'habc12, cap_target);
        run(16'hee2a, 16'hf0bc);
        chk("pointer", 20'h02abc, {6'h0, cap_ptr});
        run(16'hf123, 16'h8000);
        ends(16'h0000, 1);
    endtask
    task branch_ops;
        run(16'hd7ff, 16'h8000);
        ends(16'h8000, 1);
        chk("target", 20'h00100, cap_target);
        run(16'hd802, 16'h8000);
        ends(16'hc000, 1);
        chk("target", 20'h00103, cap_target);
        for (int c = 0; c < 16; c++) begin
            flg = 4'h0;
            flg[c/4] = c[0] ^ c[1];
            run({5'h1c, c[3:1], 8'h03}, 16'h8000);
            ends(c[0] ? 16'h8000 : 16'h0000, c % 2);
            if (c[0]) chk("target", 20'h00104, cap_target);
        end
    endtask
    task skip_ops;
        test_bit = 1'b0;
        run(16'hb000, 16'h8000);
        ends(16'h0001, 1);
        run(16'hb000, 16'hef00);
        ends(16'h0001, 2);
        run(16'ha000, 16'h8000);
        ends(16'h0000, 0);
        test_bit = 1'b1;
        run(16'ha000, 16'h8000);
        ends(16'h0001, 1);
    endtask
    task automatic literal_ops;
        logic [3:0] nib [7] = '{4'hf, 4'h8, 4'hb, 4'h9, 4'ha, 4'he, 4'hd};
        logic [4:0] fl [7] = '{5'h1f, 5'h1f, 5'h14, 5'h14, 5'h14, 5'h00, 5'h00};
        for (int i = 0; i < 7; i++) begin
            run({4'h0, nib[i], 8'h5a}, 16'h8000);
            chk("alu", 20'(i + 1), {17'h0, cap_alu});
            chk("flags", {15'h0, fl[i]}, {15'h0, cap_flg});
            chk("literal", 20'h0005a, {12'h0, cap_lit});
        end
    endtask
    task automatic control_ops;
        logic [15:0] w [11] = '{16'h0004, 16'h0003, 16'h00ff, 16'h0005, 16'h0006, 16'h0105,
            16'h0010, 16'h0011, 16'h0012, 16'h0013, 16'h0c77};
        logic [15:0] p [11] = '{16'h0080, 16'h0040, 16'h0020, 16'h0400, 16'h0200, 16'h0010,
            16'h1800, 16'h3800, 16'h1000, 16'h3000, 16'h1100};
        for (int i = 0; i < 11; i++) begin
            run(w[i], 16'h8000);
            ends(p[i], i > 5);
            if (i == 5) chk("bank", 20'h00005, {12'h0, cap_lit});
        end
        chk("literal", 20'h00077, {12'h0, cap_lit});
    endtask
    task table_ops;
        for (int m = 0; m < 8; m++) begin
            run(16'h0008 + 16'(m), 16'h0004);
            ends((m < 4 ? 16'h0004 : 16'h0002) | 16'h0080, 1);
            chk("mode", 20'(m % 4), {18'h0, cap_mode});
        end
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Run limit
    initial begin
        #200000;
        errors++;
        give_verdict();
    end
    // Reset then scenarios
    initial begin
        {reset_n_in, start, test_bit, flg, errors, total_checks} = '0;
        repeat (2) @(negedge ref_clk_in);
        reset_n_in = 1'b1;
        two_word_ops();
        branch_ops();
        skip_ops();
        literal_ops();
        control_ops();
        table_ops();
        give_verdict();
    end
endmodule // tb_control_literal_table_decoder
`default_nettype wire
